// File: core/octr_defines.svh
// constants for the octal bus transceiver with storage registers
// assumes a single system clock; every pin is sampled into that clock
`ifndef OCTR_DEFINES_SVH
`define OCTR_DEFINES_SVH
`define OCTR_WIDTH 8
`define OCTR_DATA_ZERO 8'h00
`define OCTR_DATA_ONES 8'hFF
`define OCTR_STORE_RST 8'h00
// pin to output: two synchroniser stages plus the output flop
`define OCTR_PIN_LAT 3
`define OCTR_WARM_MAX 2'h3
`define OCTR_WARM_ZERO 2'h0
`define OCTR_WARM_ONE 2'h1
`endif

// File: core/octr_pkg.sv
// types shared by the transceiver and its storage register
// assumes the constants header sits beside it
`include "octr_defines.svh"
package octr_pkg;
	typedef logic [`OCTR_WIDTH-1:0] octr_data_t;
	typedef logic [1:0] octr_warm_t;
endpackage

// File: core/octr_store_if.sv
// load request and contents of one storage register
// assumes both ends run on the system clock
`timescale 1ns/1ps
interface octr_store_if;
	import octr_pkg::*;
	logic load;
	octr_data_t d;
	octr_data_t q;
	modport store (input load, input d, output q);
	modport user (output load, output d, input q);
endinterface

// File: core/octr_store.sv
// one eight-bit storage register loaded by a one-cycle request
// assumes the request is already in the system clock domain
`timescale 1ns/1ps
`include "octr_defines.svh"
module octr_store (
	input wire logic clk_i,
	input wire logic rst_i,
	octr_store_if.store st
);
	import octr_pkg::*;
	octr_data_t q_reg;

	// reset value stands in for the undefined power-up contents
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_reg <= `OCTR_STORE_RST;
		end else if (st.load) begin
			q_reg <= st.d;
		end
	end

	assign st.q = q_reg;
endmodule

// File: core/octr_top.sv
// octal bus transceiver with one storage register per bus
// assumes every pin is asynchronous to the system clock, so each passes two
// flops (the capture clocks three); the far side holds capture data steady across its clock edge
`timescale 1ns/1ps
`include "octr_defines.svh"
module octr_top (
	input wire logic CLK_SYS_I,
	input wire logic SYS_RST_I,
	input wire octr_pkg::octr_data_t A_PORT_LINES_I,
	output logic [`OCTR_WIDTH-1:0] A_PORT_LINES_O,
	output logic [`OCTR_WIDTH-1:0] A_PORT_LINES_OE_O,
	input wire octr_pkg::octr_data_t B_PORT_LINES_I,
	output logic [`OCTR_WIDTH-1:0] B_PORT_LINES_O,
	output logic [`OCTR_WIDTH-1:0] B_PORT_LINES_OE_O,
	input wire logic B_PORT_DRIVE_ENABLE_I,
	input wire logic A_PORT_DRIVE_ENABLE_N_I,
	input wire logic A_CAPTURE_CLOCK_I,
	input wire logic B_CAPTURE_CLOCK_I,
	input wire logic B_PORT_SOURCE_SELECT_I,
	input wire logic A_PORT_SOURCE_SELECT_I
);
	import octr_pkg::*;

	octr_data_t a_s1_reg;
	octr_data_t a_s2_reg;
	octr_data_t b_s1_reg;
	octr_data_t b_s2_reg;
	logic bde_s1_reg, bde_s2_reg;
	logic ade_n_s1_reg, ade_n_s2_reg;
	logic acap_s1_reg, acap_s2_reg, acap_s3_reg;
	logic bcap_s1_reg, bcap_s2_reg, bcap_s3_reg;
	logic bsel_s1_reg, bsel_s2_reg;
	logic asel_s1_reg, asel_s2_reg;
	octr_data_t a_out_reg;
	octr_data_t b_out_reg;
	logic a_oe_reg;
	logic b_oe_reg;
	logic a_rise;
	logic b_rise;
	logic b_live_drive;
	logic a_live_drive;

	octr_store_if a_st ();
	octr_store_if b_st ();

	// picks stored contents on a high select, live data on a low one
	function automatic octr_data_t pick(input logic sel,
		input octr_data_t stored, input octr_data_t live);
		pick = sel ? stored : live;
	endfunction

	// two flops on every bus line; only the second stage feeds logic
	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			a_s1_reg <= `OCTR_DATA_ZERO;
			a_s2_reg <= `OCTR_DATA_ZERO;
			b_s1_reg <= `OCTR_DATA_ZERO;
			b_s2_reg <= `OCTR_DATA_ZERO;
		end else begin
			a_s1_reg <= A_PORT_LINES_I;
			a_s2_reg <= a_s1_reg;
			b_s1_reg <= B_PORT_LINES_I;
			b_s2_reg <= b_s1_reg;
		end
	end

	// disabled drivers and live selects are the safe state at reset
	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			bde_s1_reg <= 1'b0;
			bde_s2_reg <= 1'b0;
			ade_n_s1_reg <= 1'b1;
			ade_n_s2_reg <= 1'b1;
			bsel_s1_reg <= 1'b0;
			bsel_s2_reg <= 1'b0;
			asel_s1_reg <= 1'b0;
			asel_s2_reg <= 1'b0;
		end else begin
			bde_s1_reg <= B_PORT_DRIVE_ENABLE_I;
			bde_s2_reg <= bde_s1_reg;
			ade_n_s1_reg <= A_PORT_DRIVE_ENABLE_N_I;
			ade_n_s2_reg <= ade_n_s1_reg;
			bsel_s1_reg <= B_PORT_SOURCE_SELECT_I;
			bsel_s2_reg <= bsel_s1_reg;
			asel_s1_reg <= A_PORT_SOURCE_SELECT_I;
			asel_s2_reg <= asel_s1_reg;
		end
	end

	// capture clocks: third stage only for the edge detect
	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			acap_s1_reg <= 1'b0;
			acap_s2_reg <= 1'b0;
			acap_s3_reg <= 1'b0;
			bcap_s1_reg <= 1'b0;
			bcap_s2_reg <= 1'b0;
			bcap_s3_reg <= 1'b0;
		end else begin
			acap_s1_reg <= A_CAPTURE_CLOCK_I;
			acap_s2_reg <= acap_s1_reg;
			acap_s3_reg <= acap_s2_reg;
			bcap_s1_reg <= B_CAPTURE_CLOCK_I;
			bcap_s2_reg <= bcap_s1_reg;
			bcap_s3_reg <= bcap_s2_reg;
		end
	end

	// capture ignores enables and selects except to route the copy path
	assign a_rise = acap_s2_reg & ~acap_s3_reg;
	assign b_rise = bcap_s2_reg & ~bcap_s3_reg;
	assign b_live_drive = bde_s2_reg & ~bsel_s2_reg;
	assign a_live_drive = ~ade_n_s2_reg & ~asel_s2_reg;

	// a live-driven bus carries the other side, so load that value directly;
	// this keeps the copy exact despite our own pin-to-pin latency
	assign a_st.load = a_rise;
	assign a_st.d = a_live_drive ? b_s2_reg : a_s2_reg;
	assign b_st.load = b_rise;
	assign b_st.d = b_live_drive ? a_s2_reg : b_s2_reg;

	octr_store u_a_store (
		.clk_i(CLK_SYS_I),
		.rst_i(SYS_RST_I),
		.st(a_st.store)
	);

	octr_store u_b_store (
		.clk_i(CLK_SYS_I),
		.rst_i(SYS_RST_I),
		.st(b_st.store)
	);

	// outputs leave a flop, so a select change moves the bus once, cleanly
	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			b_out_reg <= `OCTR_DATA_ZERO;
			a_out_reg <= `OCTR_DATA_ZERO;
		end else begin
			b_out_reg <= pick(bsel_s2_reg, a_st.q, a_s2_reg);
			a_out_reg <= pick(asel_s2_reg, b_st.q, b_s2_reg);
		end
	end

	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			b_oe_reg <= 1'b0;
			a_oe_reg <= 1'b0;
		end else begin
			b_oe_reg <= bde_s2_reg;
			a_oe_reg <= ~ade_n_s2_reg;
		end
	end

	assign A_PORT_LINES_O = a_out_reg;
	assign B_PORT_LINES_O = b_out_reg;
	assign A_PORT_LINES_OE_O = {`OCTR_WIDTH{a_oe_reg}};
	assign B_PORT_LINES_OE_O = {`OCTR_WIDTH{b_oe_reg}};

	// helper for assertions: pipelines settle a few cycles after reset
	octr_warm_t warm_reg;
	always_ff @(posedge CLK_SYS_I) begin
		if (SYS_RST_I) begin
			warm_reg <= `OCTR_WARM_ZERO;
		end else if (warm_reg != `OCTR_WARM_MAX) begin
			warm_reg <= octr_warm_t'(warm_reg + `OCTR_WARM_ONE);
		end
	end

	default clocking cb @(posedge CLK_SYS_I);
	endclocking
	default disable iff (SYS_RST_I || warm_reg != `OCTR_WARM_MAX);

	a_lines_share_oe: assert property (
		A_PORT_LINES_OE_O inside {`OCTR_DATA_ZERO, `OCTR_DATA_ONES} &&
		B_PORT_LINES_OE_O inside {`OCTR_DATA_ZERO, `OCTR_DATA_ONES})
		else $error("port line enables disagree");

	a_drive_gate: assert property (
		B_PORT_LINES_OE_O[0] ==
			$past(B_PORT_DRIVE_ENABLE_I, `OCTR_PIN_LAT) &&
		A_PORT_LINES_OE_O[0] ==
			!$past(A_PORT_DRIVE_ENABLE_N_I, `OCTR_PIN_LAT))
		else $error("driver enable does not follow its pin");

	a_b_live_pass: assert property (
		!$past(B_PORT_SOURCE_SELECT_I, `OCTR_PIN_LAT) |->
		B_PORT_LINES_O == $past(A_PORT_LINES_I, `OCTR_PIN_LAT))
		else $error("port B does not follow live port A");

	a_b_stored_out: assert property (
		$past(B_PORT_SOURCE_SELECT_I, `OCTR_PIN_LAT) |->
		B_PORT_LINES_O == $past(a_st.q))
		else $error("port B does not show the A register");

	a_a_live_pass: assert property (
		!$past(A_PORT_SOURCE_SELECT_I, `OCTR_PIN_LAT) |->
		A_PORT_LINES_O == $past(B_PORT_LINES_I, `OCTR_PIN_LAT))
		else $error("port A does not follow live port B");

	a_a_stored_out: assert property (
		$past(A_PORT_SOURCE_SELECT_I, `OCTR_PIN_LAT) |->
		A_PORT_LINES_O == $past(b_st.q))
		else $error("port A does not show the B register");

	a_cross_stored: assert property (
		(a_oe_reg && b_oe_reg && $past(asel_s2_reg) &&
			$past(bsel_s2_reg)) |->
		(A_PORT_LINES_O == $past(b_st.q) &&
			B_PORT_LINES_O == $past(a_st.q)))
		else $error("stored data does not cross over");

	a_a_capture: assert property (
		(a_rise && !a_live_drive) |=>
		a_st.q == $past(A_PORT_LINES_I, `OCTR_PIN_LAT))
		else $error("A register missed its port");

	a_copy_a_both: assert property (
		(a_rise && b_rise && b_live_drive && !a_live_drive) |=>
		(a_st.q == b_st.q &&
			b_st.q == $past(A_PORT_LINES_I, `OCTR_PIN_LAT)))
		else $error("port A not copied into both registers");

	a_copy_b_both: assert property (
		(a_rise && b_rise && a_live_drive && !b_live_drive) |=>
		(a_st.q == b_st.q &&
			a_st.q == $past(B_PORT_LINES_I, `OCTR_PIN_LAT)))
		else $error("port B not copied into both registers");

	a_hold_between: assert property (
		!a_rise |=> $stable(a_st.q))
		else $error("A register changed without a capture edge");

	a_single_capture: assert property (
		(b_rise && !a_rise) ##1 1'b1 |-> $stable(a_st.q))
		else $error("lone B capture disturbed the A register");

	a_live_reinforce: assert property (
		(a_oe_reg && b_oe_reg && !$past(asel_s2_reg) &&
			!$past(bsel_s2_reg)) |->
		(A_PORT_LINES_O == $past(B_PORT_LINES_I, `OCTR_PIN_LAT) &&
			B_PORT_LINES_O == $past(A_PORT_LINES_I, `OCTR_PIN_LAT)))
		else $error("ports do not reinforce each other");

	a_select_clean: assert property (
		($past(bsel_s2_reg) != $past(bsel_s2_reg, 2) &&
			$past(a_st.q) == $past(a_s2_reg) &&
			$past(a_st.q, 2) == $past(a_s2_reg, 2) &&
			$past(a_s2_reg) == $past(a_s2_reg, 2)) |->
		$stable(B_PORT_LINES_O))
		else $error("select change moved port B");

	c_isolate_store: cover property (
		!a_oe_reg && !b_oe_reg && a_rise && b_rise);
	c_copy_a: cover property (a_rise && b_rise && b_live_drive);
	c_cross: cover property (a_oe_reg && b_oe_reg && asel_s2_reg &&
		bsel_s2_reg);
	c_hold: cover property (a_oe_reg && b_oe_reg && a_live_drive &&
		b_live_drive);
endmodule

// File: verification/octr_bus_agent.sv
// bus agents on both sides of the transceiver, with wire resolution
// assumes per-line enables from the transceiver and agent values from the bench
`timescale 1ns/1ps
module octr_bus_agent (
	input wire logic clk_i,
	input wire octr_pkg::octr_data_t a_o_i,
	input wire octr_pkg::octr_data_t a_oe_i,
	input wire octr_pkg::octr_data_t b_o_i,
	input wire octr_pkg::octr_data_t b_oe_i,
	input wire logic a_drv_i,
	input wire octr_pkg::octr_data_t a_val_i,
	input wire logic b_drv_i,
	input wire octr_pkg::octr_data_t b_val_i,
	output octr_pkg::octr_data_t a_bus_o,
	output octr_pkg::octr_data_t b_bus_o
);
	import octr_pkg::*;
	octr_data_t a_flt_reg = 8'h00;
	octr_data_t b_flt_reg = 8'h00;
	// a line nobody drives changes every cycle, so a stale value never passes
	always @(posedge clk_i) begin
		a_flt_reg <= ~a_bus_o;
		b_flt_reg <= ~b_bus_o;
	end
	// per line: transceiver drive first, then the agent, else floating
	assign a_bus_o = (a_oe_i & a_o_i) |
		(~a_oe_i & (a_drv_i ? a_val_i : a_flt_reg));
	assign b_bus_o = (b_oe_i & b_o_i) |
		(~b_oe_i & (b_drv_i ? b_val_i : b_flt_reg));
endmodule

// File: verification/tb_octr_top.sv
// self-checking testbench for the octal transceiver with storage registers
// assumes the agent model resolves both buses from all enables
`timescale 1ns/1ps
module tb_octr_top;
	import octr_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic b_en = 1'b0, a_en_n = 1'b1, a_cap = 1'b0, b_cap = 1'b0;
	logic b_sel = 1'b0, a_sel = 1'b0, a_drv = 1'b0, b_drv = 1'b0;
	octr_data_t a_val = 8'h00, b_val = 8'h00;
	octr_data_t a_bus, b_bus, a_o, b_o, a_oe, b_oe;
	int err_total = 0;
	int comparisons = 0;
	always #10 clk = ~clk;
	octr_top u_octr_top (.CLK_SYS_I(clk), .SYS_RST_I(rst),
		.A_PORT_LINES_I(a_bus), .A_PORT_LINES_O(a_o),
		.A_PORT_LINES_OE_O(a_oe), .B_PORT_LINES_I(b_bus),
		.B_PORT_LINES_O(b_o), .B_PORT_LINES_OE_O(b_oe),
		.B_PORT_DRIVE_ENABLE_I(b_en), .A_PORT_DRIVE_ENABLE_N_I(a_en_n),
		.A_CAPTURE_CLOCK_I(a_cap), .B_CAPTURE_CLOCK_I(b_cap),
		.B_PORT_SOURCE_SELECT_I(b_sel), .A_PORT_SOURCE_SELECT_I(a_sel));
	octr_bus_agent u_octr_bus_agent (.clk_i(clk), .a_o_i(a_o),
		.a_oe_i(a_oe), .b_o_i(b_o), .b_oe_i(b_oe), .a_drv_i(a_drv),
		.a_val_i(a_val), .b_drv_i(b_drv), .b_val_i(b_val),
		.a_bus_o(a_bus), .b_bus_o(b_bus));
	task automatic chk(input string what, input octr_data_t exp,
		input octr_data_t got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	// capture pins held well over two system cycles high and low
	task automatic cap(input logic ca, input logic cb);
		a_cap = ca;
		b_cap = cb;
		step(3);
		a_cap = 1'b0;
		b_cap = 1'b0;
		step(3);
	endtask
	task automatic t_isolate;
		a_drv = 1'b1;
		b_drv = 1'b1;
		step(8);
		chk("a_oe", 8'h00, a_oe);
		chk("b_oe", 8'h00, b_oe);
		b_drv = 1'b0;
		b_en = 1'b1;
		step(8);
		chk("b_oe", 8'hFF, b_oe);
		chk("a_oe", 8'h00, a_oe);
		b_en = 1'b0;
		// the B drivers must let go before the next test captures port B
		step(8);
		chk("b_oe", 8'h00, b_oe);
		$display("test isolate done");
	endtask
	task automatic t_store;
		a_drv = 1'b1;
		b_drv = 1'b1;
		a_val = 8'h11;
		b_val = 8'h22;
		// data settles a cycle ahead of the capture edge
		step(1);
		cap(1'b1, 1'b1);
		a_val = 8'h3C;
		step(1);
		cap(1'b1, 1'b0);
		a_drv = 1'b0;
		b_drv = 1'b0;
		b_en = 1'b1;
		a_en_n = 1'b0;
		b_sel = 1'b1;
		a_sel = 1'b1;
		step(8);
		chk("b_bus", 8'h3C, b_bus);
		chk("a_bus", 8'h22, a_bus);
		b_en = 1'b0;
		a_en_n = 1'b1;
		$display("test store done");
	endtask
	task automatic t_live_ab;
		step(1);
		b_en = 1'b1;
		b_sel = 1'b0;
		a_drv = 1'b1;
		a_val = 8'h5A;
		step(8);
		chk("b_bus", 8'h5A, b_bus);
		a_val = 8'hA5;
		step(8);
		chk("b_bus", 8'hA5, b_bus);
		cap(1'b1, 1'b1);
		b_sel = 1'b1;
		// live and stored agree, so any stray value is a glitch
		repeat (8) begin
			step(1);
			chk("b_bus", 8'hA5, b_bus);
		end
		a_drv = 1'b0;
		a_en_n = 1'b0;
		a_sel = 1'b1;
		step(8);
		chk("a_bus", 8'hA5, a_bus);
		chk("b_bus", 8'hA5, b_bus);
		b_en = 1'b0;
		$display("test live a to b done");
	endtask
	task automatic t_live_ba;
		a_sel = 1'b0;
		b_drv = 1'b1;
		b_val = 8'h69;
		step(8);
		chk("a_bus", 8'h69, a_bus);
		cap(1'b1, 1'b1);
		a_sel = 1'b1;
		b_val = 8'h0F;
		step(8);
		chk("a_bus", 8'h69, a_bus);
		// select high: clocks staggered so the A register takes the new value
		cap(1'b0, 1'b1);
		step(4);
		cap(1'b1, 1'b0);
		b_drv = 1'b0;
		b_en = 1'b1;
		b_sel = 1'b1;
		step(8);
		chk("b_bus", 8'h0F, b_bus);
		$display("test live b to a done");
	endtask
	task automatic t_hold;
		b_en = 1'b1;
		a_en_n = 1'b1;
		b_sel = 1'b0;
		a_sel = 1'b0;
		a_drv = 1'b1;
		a_val = 8'hC6;
		step(8);
		a_en_n = 1'b0;
		step(8);
		a_drv = 1'b0;
		step(20);
		chk("a_bus", 8'hC6, a_bus);
		chk("b_bus", 8'hC6, b_bus);
		$display("test hold done");
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		step(2);
		rst = 1'b0;
		chk("a_oe", 8'h00, a_oe);
		t_isolate();
		t_store();
		t_live_ab();
		t_live_ba();
		t_hold();
		conclude();
	end
	// the tests need about 170 cycles; this allows 3000, over seventeen times that
	initial begin
		#60000;
		err_total++;
		conclude();
	end
endmodule
